// ===== common/aps_defines.vh
// Register offsets, field positions and reset values for the protection status bank.
`ifndef APS_DEFINES_VH
`define APS_DEFINES_VH
`define APS_ADDR_POWER_LIMIT 8'h14
`define APS_ADDR_MISC_STATUS 8'h15
`define APS_POWER_LIMIT_RESET 8'hBD
`define APS_BIT_OUTPUT_SWITCHING 14
`define APS_BIT_REGULATOR_GOOD 13
`define APS_FLD_PHASE_HI 10
`define APS_FLD_PHASE_LO 9
`define APS_BIT_RATIO_BAD2 8
`define APS_BIT_RATE_HIGH2 7
`define APS_BIT_RATE_LOW2 6
`define APS_BIT_RATIO_BAD1 5
`define APS_BIT_RATE_HIGH1 4
`define APS_BIT_RATE_LOW1 3
`define APS_BIT_OC_CLEAR_A 2
`define APS_BIT_OC_CLEAR_B 1
`define APS_BIT_THERMAL_OK 0
`define APS_PHASE_OFF 2'h0
`define APS_PHASE_START1 2'h1
`define APS_PHASE_START2 2'h2
`define APS_PHASE_ON 2'h3
`endif

// ===== verilog/aps_input_check.v
// Per-input audio clock check flag register for one serial input.
`timescale 1ns/1ps
`default_nettype none
module aps_input_check
(
    input wire core_clk,
    input wire reset,
    input wire clk_en,
    input wire clock_ratio_bad_in,
    input wire rate_too_high_in,
    input wire rate_too_low_in,
    output reg [2:0] flags_q
);
    // Ordering is {ratio bad, rate too high, rate too low}, matching the field layout.
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            flags_q <= 3'h0;
        end
        else if (clk_en)
        begin
            // A rate cannot be both too high and too low; too high takes precedence.
            flags_q <= {clock_ratio_bad_in, rate_too_high_in, rate_too_low_in & ~rate_too_high_in};
        end
    end
endmodule
`default_nettype wire

// ===== verilog/aps_status_bank.v
// Protection status register bank with the power limit level setting.
//
// Overview of operation
// - Eight-bit limit level, read/write, resets to BD
// - Bit 14 high while output stage switches
// - Bit 13 high only when regulator good
// - Bits 10:9 report off, start-up, functional phase
// - Bit 8 flags input-2 clock ratio invalid
// - Bit 7 flags input-2 frame rate too high
// - Bit 6 flags input-2 frame rate too low
// - Bit 5 flags input-1 clock ratio invalid
// - Bit 4 flags input-1 frame rate too high
// - Bit 3 flags input-1 frame rate too low
// - Bit 2 low while positive-pin overcurrent active
// - Bit 1 low while negative-pin overcurrent active
// - Bit 0 low while overtemperature protection active
`timescale 1ns/1ps
`default_nettype none
`include "aps_defines.vh"
module aps_status_bank
(
    input wire core_clk,
    input wire reset,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    input wire reg_rd,
    input wire output_switching,
    input wire regulator_good,
    input wire [1:0] gain_stage_phase,
    input wire [1:0] clock_ratio_bad_flag,
    input wire [1:0] rate_too_high_flag,
    input wire [1:0] rate_too_low_flag,
    input wire overcurrent_a,
    input wire overcurrent_b,
    input wire overtemp,
    output reg [15:0] reg_rdata_q,
    output reg [7:0] power_limit_level_q,
    output reg [15:0] status_q
);
    // ----------------------------------------------------------------
    // Per-input clock checks
    // ----------------------------------------------------------------
    wire [5:0] chk_flags;
    wire [2:0] in1_flags;
    wire [2:0] in2_flags;
    genvar g;

    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gen_check
            aps_input_check u_check
            (
                .core_clk(core_clk),
                .reset(reset),
                .clk_en(clk_en),
                .clock_ratio_bad_in(clock_ratio_bad_flag[g]),
                .rate_too_high_in(rate_too_high_flag[g]),
                .rate_too_low_in(rate_too_low_flag[g]),
                .flags_q(chk_flags[3*g+2:3*g])
            );
        end
    endgenerate

    assign in1_flags = chk_flags[2:0];
    assign in2_flags = chk_flags[5:3];

    // ----------------------------------------------------------------
    // Status word assembly
    // ----------------------------------------------------------------
    reg [15:0] status_d;

    always @*
    begin
        status_d = 16'h0000;
        status_d[`APS_BIT_OUTPUT_SWITCHING] = output_switching;
        status_d[`APS_BIT_REGULATOR_GOOD] = regulator_good;
        status_d[`APS_FLD_PHASE_HI:`APS_FLD_PHASE_LO] = gain_stage_phase;
        status_d[`APS_BIT_RATIO_BAD2] = in2_flags[2];
        status_d[`APS_BIT_RATE_HIGH2] = in2_flags[1];
        status_d[`APS_BIT_RATE_LOW2] = in2_flags[0];
        status_d[`APS_BIT_RATIO_BAD1] = in1_flags[2];
        status_d[`APS_BIT_RATE_HIGH1] = in1_flags[1];
        status_d[`APS_BIT_RATE_LOW1] = in1_flags[0];
        status_d[`APS_BIT_OC_CLEAR_A] = ~overcurrent_a;
        status_d[`APS_BIT_OC_CLEAR_B] = ~overcurrent_b;
        status_d[`APS_BIT_THERMAL_OK] = ~overtemp;
    end

    // ----------------------------------------------------------------
    // Registers and read port
    // ----------------------------------------------------------------
    // The clock flags pass through one extra stage, so in status_q they lag the
    // other bits by one cycle and a read mixes two sampling instants.
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            status_q <= 16'h0000;
            power_limit_level_q <= `APS_POWER_LIMIT_RESET;
            reg_rdata_q <= 16'h0000;
        end
        else if (clk_en)
        begin
            status_q <= status_d;
            // Writes to the status address fall through and change nothing.
            if (reg_wr && reg_addr == `APS_ADDR_POWER_LIMIT)
            begin
                power_limit_level_q <= reg_wdata[7:0];
            end
            if (reg_rd)
            begin
                case (reg_addr)
                    `APS_ADDR_POWER_LIMIT: reg_rdata_q <= {8'h00, power_limit_level_q};
                    `APS_ADDR_MISC_STATUS: reg_rdata_q <= status_q;
                    default: reg_rdata_q <= 16'h0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/aps_host_model.sv
// Host model that drives the register strobes of the status bank.
`timescale 1ns/1ps
`default_nettype none
module aps_host_model
(
    input wire logic core_clk,
    input wire logic [15:0] reg_rdata_q,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    // Released write data is inverted so a stale value never reads as valid.
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(negedge core_clk);
        {reg_addr, reg_wr, reg_rd, reg_wdata} = {a, w, !w, d};
        @(negedge core_clk);
        {reg_wr, reg_rd, reg_wdata} = {2'h0, ~d};
        q = reg_rdata_q;
    endtask
endmodule
`default_nettype wire

// ===== verification/aps_status_bank_properties.sv
// Concurrent checks on the status bank ports.
`timescale 1ns/1ps
`default_nettype none
module aps_status_bank_properties
(
    input wire logic core_clk, reset, clk_en, reg_wr, reg_rd, output_switching,
    input wire logic regulator_good, overcurrent_a, overcurrent_b, overtemp,
    input wire logic [1:0] gain_stage_phase, clock_ratio_bad_flag,
    input wire logic [7:0] reg_addr, power_limit_level_q,
    input wire logic [15:0] reg_wdata, reg_rdata_q, status_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_limit_wr: assert property (clk_en && reg_wr && reg_addr == 8'h14 |=>
        power_limit_level_q == $past(reg_wdata[7:0])) else $error("limit write");
    chk_switch_bit: assert property (clk_en |=> status_q[14] == $past(output_switching))
        else $error("bit 14");
    chk_reg_bit: assert property (clk_en |=> status_q[13] == $past(regulator_good))
        else $error("bit 13");
    chk_phase_fld: assert property (clk_en |=> status_q[10:9] == $past(gain_stage_phase))
        else $error("phase");
    chk_ratio_flags: assert property (clk_en && $past(clk_en) && !$past(reset) |=>
        {status_q[8], status_q[5]} == $past(clock_ratio_bad_flag, 2)) else $error("ratio");
    chk_prot_bits: assert property (clk_en |=>
        status_q[2:0] == ~$past({overcurrent_a, overcurrent_b, overtemp})) else $error("prot");
    chk_resv_zero: assert property (status_q[15] == 1'h0 && status_q[12:11] == 2'h0)
        else $error("reserved");
    chk_status_read: assert property (clk_en && reg_rd && reg_addr == 8'h15 |=>
        reg_rdata_q == $past(status_q)) else $error("status read");
    cover property (clk_en && reg_rd && reg_addr == 8'h15);
    cover property (!clk_en && reg_wr);
    cover property (status_q[3] || status_q[6]);
endmodule
bind aps_status_bank aps_status_bank_properties u_chk (.*);
`default_nettype wire

// ===== verification/aps_status_bank_tb.sv
// Self-checking bench for the protection status bank.
`timescale 1ns/1ps
`default_nettype none
module aps_status_bank_tb;
    logic core_clk = 1'h0;
    logic reset = 1'h1;
    logic clk_en = 1'h1;
    logic output_switching, regulator_good, overcurrent_a, overcurrent_b, overtemp;
    logic [1:0] gain_stage_phase, clock_ratio_bad_flag, rate_too_high_flag, rate_too_low_flag;
    logic [7:0] reg_addr, power_limit_level_q;
    logic reg_wr, reg_rd;
    logic [15:0] reg_wdata, reg_rdata_q, status_q, q, d;
    logic [7:0] lim_m = 8'hBD;
    int err_count = 0;
    int n_compared = 0;
    aps_status_bank dut (.*);
    aps_host_model u_host (.*);
    initial forever #2 core_clk = ~core_clk;
    task automatic rnd();
        {output_switching, regulator_good, gain_stage_phase, clock_ratio_bad_flag,
            rate_too_high_flag, rate_too_low_flag, overcurrent_a, overcurrent_b,
            overtemp} = 13'($urandom);
    endtask
    // Rate-too-low is masked whenever rate-too-high is raised on the same input.
    function automatic logic [15:0] exp_st();
        return {1'h0, output_switching, regulator_good, 2'h0, gain_stage_phase,
            clock_ratio_bad_flag[1], rate_too_high_flag[1], rate_too_low_flag[1] &
            ~rate_too_high_flag[1], clock_ratio_bad_flag[0], rate_too_high_flag[0],
            rate_too_low_flag[0] & ~rate_too_high_flag[0], ~overcurrent_a, ~overcurrent_b,
            ~overtemp};
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        void'($urandom(69405));
        rnd();
        repeat (6) @(posedge core_clk);
        @(negedge core_clk) reset = 1'h0;
        u_host.access(1'h0, 8'h14, 16'h0, q);
        cmp(q, {8'h00, lim_m});
        for (int i = 0; i < 40; i++)
        begin
            @(negedge core_clk) rnd();
            d = 16'($urandom);
            clk_en = (i % 5 != 0);
            u_host.access(1'h1, 8'h14, d, q);
            if (clk_en)
                lim_m = d[7:0];
            u_host.access(1'h1, 8'h15, ~d, q);
            clk_en = 1'h1;
            u_host.access(1'h0, 8'h14, 16'h0, q);
            cmp(q, {8'h00, lim_m});
            cmp({8'h00, power_limit_level_q}, {8'h00, lim_m});
            cmp(status_q, exp_st());
            u_host.access(1'h0, 8'h15, 16'h0, q);
            cmp(q, exp_st());
            u_host.access(1'h0, 8'h80 | 8'(i), 16'h0, q);
            cmp(q, 16'h0000);
            $display("test %0d done", i);
        end
        print_verdict();
    end
    // About 40 passes of 11 cycles each; the limit leaves a wide margin.
    initial
    begin
        #20000;
        err_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
